// ===== rtl/csss_pkg.sv
// shared constants and types of the clock source start-up sequencer
package csss_pkg;

    // ------------------------------------------------------------
    // fuse field encodings (a stored 1 means unprogrammed)
    // ------------------------------------------------------------
    localparam logic       FUSE_PROG     = 1'b0;
    localparam logic [3:0] SRC_EXT       = 4'h0;
    localparam logic [3:0] SRC_RSVD      = 4'h1;
    localparam logic [3:0] SRC_RC8M      = 4'h2;
    localparam logic [3:0] SRC_RC128K    = 4'h3;
    localparam logic [3:0] SRC_LF_1K     = 4'h4;
    localparam logic [3:0] SRC_LF_32K    = 4'h5;
    localparam logic [1:0] SUT_RSVD      = 2'h3;

    // ------------------------------------------------------------
    // factory default fuse image
    // ------------------------------------------------------------
    localparam logic [3:0] DEF_SRC       = 4'h2;
    localparam logic [1:0] DEF_SUT       = 2'h2;
    localparam logic       DEF_DIV8      = 1'b0;

    // ------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------
    localparam logic [13:0] TOUT_NONE    = 14'h0000;
    localparam logic [13:0] TOUT_SHORT   = 14'h0200;
    localparam logic [16:0] CK_6         = 17'h00006;
    localparam logic [16:0] CK_258       = 17'h00102;
    localparam logic [16:0] CK_1K        = 17'h00400;
    localparam logic [16:0] CK_RESET_ADD = 17'h00013;
    localparam logic [2:0]  DIV8_LAST    = 3'h7;

    // ------------------------------------------------------------
    // register map (byte offsets) and fields
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CONFIG    = 4'h0;
    localparam logic [3:0] REG_STATUS    = 4'h4;
    localparam logic [3:0] REG_CONTROL   = 4'h8;
    localparam int         CFG_SRC_LSB   = 0;
    localparam int         CFG_SUT_LSB   = 4;
    localparam int         CFG_DIV8_BIT  = 6;
    localparam int         CTL_SLEEP_BIT = 0;
    localparam int         CTL_WAKE_BIT  = 1;
    localparam int         CTL_NOISE_BIT = 2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_EXT, KIND_RC128K, KIND_RC8M, KIND_LFXTAL, KIND_LPXTAL, KIND_RSVD
    } csss_kind_e;

    typedef enum logic [1:0] {
        TSEL_NONE, TSEL_SHORT, TSEL_LONG
    } csss_tsel_e;

    typedef enum logic [2:0] {
        ST_HOLD  = 3'b000,
        ST_TOUT  = 3'b001,
        ST_OSC   = 3'b011,
        ST_RUN   = 3'b010,
        ST_SLEEP = 3'b110
    } csss_state_e;

    function automatic csss_kind_e csss_kind(input logic [3:0] src);
        if (src[3])
            return KIND_LPXTAL;
        unique case (src)
            SRC_LF_1K, SRC_LF_32K: return KIND_LFXTAL;
            SRC_RC128K:            return KIND_RC128K;
            SRC_RC8M:              return KIND_RC8M;
            SRC_EXT:               return KIND_EXT;
            default:               return KIND_RSVD;
        endcase
    endfunction : csss_kind

endpackage : csss_pkg

// ===== rtl/csss_sync.sv
// two flip-flop synchroniser for pin and foreign-clock inputs
`timescale 1ns/1ps
module csss_sync
    import csss_pkg::*;
#(
    parameter int              W    = 1,
    parameter logic [W-1:0]    INIT = '0
) (
    // clock and control
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    // asynchronous in, synchronised out
    input  wire logic [W-1:0]  d_in,
    output logic      [W-1:0]  d_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } csss_sync_s;

    csss_sync_s st_q;
    csss_sync_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = d_in;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '{s1: INIT, s2: INIT};
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign d_out = st_q.s2;

endmodule : csss_sync

// ===== rtl/csss_div8.sv
// system clock prescaler: one tick per oscillator cycle, or per eight
`timescale 1ns/1ps
module csss_div8
    import csss_pkg::*;
(
    // clock and control
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  ce,
    // oscillator cycles in, system ticks out
    input  wire logic  osc_edge,
    input  wire logic  run,
    input  wire logic  div8_on,
    output logic       tick
);

    typedef struct packed {
        logic [2:0] cnt;
        logic       tick;
    } csss_div_s;

    csss_div_s st_q;
    csss_div_s st_d;

    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (!run) begin
            st_d.cnt = '0;
        end else if (osc_edge) begin
            st_d.cnt  = st_q.cnt + 3'h1;
            st_d.tick = !div8_on || (st_q.cnt == DIV8_LAST);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

    property p_div8_gap;
        @(posedge clk) disable iff (rst)
        (tick && div8_on && run) |=> !tick [*7];
    endproperty
    a_div8_gap: assert property (p_div8_gap) else $error("divided tick too soon");

endmodule : csss_div8

// ===== rtl/csss_sequencer.sv
// clock source selection and reset release sequencer, top level
`timescale 1ns/1ps
module csss_sequencer
    import csss_pkg::*;
#(
    parameter logic [13:0] TOUT_LONG_CYC = 14'h2000,
    parameter logic [16:0] CK_16K_CYC    = 17'h04000,
    parameter logic [16:0] CK_32K_CYC    = 17'h08000
) (
    // clock and control
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // avalon-mm slave
    input  wire logic [3:0]   avs_address,
    input  wire logic [3:0]   avs_byteenable,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    output logic      [31:0]  avs_readdata,
    output logic              avs_waitrequest,
    // reset sources and oscillators (asynchronous)
    input  wire logic         ext_reset_in,
    input  wire logic         wdt_osc_in,
    input  wire logic         sel_osc_in,
    input  wire logic         async_osc_in,
    // core side
    output logic              core_reset,
    output logic              core_clock_en,
    output logic              converter_clock_en,
    output logic              async_timer_clock_en,
    output logic      [2:0]   source_kind,
    output logic      [2:0]   crystal_range_select,
    output logic              clock_select_low_bit,
    output logic              fuse_fault
);

    // ------------------------------------------------------------
    // start-up decode
    // ------------------------------------------------------------
    function automatic csss_tsel_e tout_sel(input logic [3:0] src, input logic [1:0] sut);
        if (src[3]) begin
            unique case ({src[0], sut})
                3'h0, 3'h3, 3'h6: return TSEL_SHORT;
                3'h1, 3'h4, 3'h7: return TSEL_LONG;
                default:          return TSEL_NONE;
            endcase
        end
        unique case (sut)
            2'h0:    return TSEL_NONE;
            2'h1:    return TSEL_SHORT;
            default: return TSEL_LONG;
        endcase
    endfunction : tout_sel

    function automatic logic [16:0] osc_cycles(input logic [3:0] src, input logic [1:0] sut);
        if (src[3]) begin
            if (src[0])
                return (sut == 2'h0) ? CK_1K : CK_16K_CYC;
            return sut[1] ? CK_1K : CK_258;
        end
        unique case (src)
            SRC_LF_1K:  return CK_1K;
            SRC_LF_32K: return CK_32K_CYC;
            default:    return CK_6;
        endcase
    endfunction : osc_cycles

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        csss_state_e state;
        logic [3:0]  cfg_src;
        logic [1:0]  cfg_sut;
        logic        cfg_div8;
        logic        noise;
        logic [3:0]  src;
        logic [1:0]  sut;
        logic        div8;
        logic [2:0]  kind;
        logic        fault;
        logic        waking;
        logic [13:0] wdt_cnt;
        logic [16:0] osc_cnt;
        logic        wdt_prev;
        logic        osc_prev;
        logic        asy_prev;
        logic        core_reset;
        logic        cpu_en;
        logic        adc_en;
        logic        asy_en;
        logic        rd_done;
        logic [31:0] rdata;
    } csss_main_s;

    csss_main_s  st_q;
    csss_main_s  st_d;
    logic [3:0]  pins_s;
    logic        rst_src, wdt_lvl, osc_lvl, asy_lvl;
    logic        wdt_edge, osc_edge, asy_edge;
    logic        sys_tick;
    logic [13:0] tout_len;
    logic [16:0] osc_target;
    logic        wr_cfg, wr_ctl;

    // reset source starts high so the first cycles after rst stay held
    csss_sync #(.W (4), .INIT (4'h8)) u_sync (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .d_in  ({ext_reset_in, wdt_osc_in, sel_osc_in, async_osc_in}),
        .d_out (pins_s)
    );

    assign rst_src  = pins_s[3];
    assign wdt_lvl  = pins_s[2];
    assign osc_lvl  = pins_s[1];
    assign asy_lvl  = pins_s[0];
    assign wdt_edge = wdt_lvl && !st_q.wdt_prev;
    assign osc_edge = osc_lvl && !st_q.osc_prev;
    assign asy_edge = asy_lvl && !st_q.asy_prev;

    csss_div8 u_div8 (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .osc_edge (osc_edge),
        .run      (st_q.state == ST_RUN),
        .div8_on  (st_q.div8 == FUSE_PROG),
        .tick     (sys_tick)
    );

    always_comb begin
        unique case (tout_sel(st_q.src, st_q.sut))
            TSEL_SHORT: tout_len = TOUT_SHORT;
            TSEL_LONG:  tout_len = TOUT_LONG_CYC;
            default:    tout_len = TOUT_NONE;
        endcase
    end

    // reset adds 19 cycles on top of the wake-up count
    assign osc_target = osc_cycles(st_q.src, st_q.sut)
                      + (st_q.waking ? 17'h00000 : CK_RESET_ADD);

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    assign wr_cfg = avs_write && avs_byteenable[0] && (avs_address == REG_CONFIG);
    assign wr_ctl = avs_write && avs_byteenable[0] && (avs_address == REG_CONTROL);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d          = st_q;
        st_d.wdt_prev = wdt_lvl;
        st_d.osc_prev = osc_lvl;
        st_d.asy_prev = asy_lvl;
        st_d.rd_done  = avs_read && !st_q.rd_done;
        st_d.rdata    = '0;
        if (avs_read && !st_q.rd_done) begin
            unique case (avs_address)
                REG_CONFIG:  st_d.rdata = {25'h0, st_q.cfg_div8, st_q.cfg_sut, st_q.cfg_src};
                REG_STATUS:  st_d.rdata = {23'h0, st_q.waking, st_q.fault, st_q.core_reset,
                                           st_q.kind, st_q.state};
                REG_CONTROL: st_d.rdata = {29'h0, st_q.noise, 2'h0};
                default:     st_d.rdata = '0;
            endcase
        end
        // new fuse image is only picked up at the next reset capture
        if (wr_cfg) begin
            st_d.cfg_src  = avs_writedata[CFG_SRC_LSB +: 4];
            st_d.cfg_sut  = avs_writedata[CFG_SUT_LSB +: 2];
            st_d.cfg_div8 = avs_writedata[CFG_DIV8_BIT];
        end
        if (wr_ctl) begin
            st_d.noise = avs_writedata[CTL_NOISE_BIT];
        end

        unique case (st_q.state)
            ST_HOLD: begin
                st_d.src     = st_q.cfg_src;
                st_d.sut     = st_q.cfg_sut;
                st_d.div8    = st_q.cfg_div8;
                st_d.kind    = csss_kind(st_q.cfg_src);
                st_d.fault   = (st_q.cfg_src == SRC_RSVD)
                            || (!st_q.cfg_src[3] && st_q.cfg_sut == SUT_RSVD);
                st_d.waking  = 1'b0;
                st_d.wdt_cnt = '0;
                st_d.osc_cnt = '0;
                if (!rst_src) begin
                    st_d.state = ST_TOUT;
                end
            end
            ST_TOUT: begin
                if (st_q.wdt_cnt == tout_len) begin
                    st_d.state   = ST_OSC;
                    st_d.osc_cnt = '0;
                end else if (wdt_edge) begin
                    st_d.wdt_cnt = st_q.wdt_cnt + 14'h0001;
                end
            end
            ST_OSC: begin
                if (st_q.osc_cnt == osc_target) begin
                    st_d.state = ST_RUN;
                end else if (osc_edge) begin
                    st_d.osc_cnt = st_q.osc_cnt + 17'h00001;
                end
            end
            ST_RUN: begin
                if (wr_ctl && avs_writedata[CTL_SLEEP_BIT]) begin
                    st_d.state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wr_ctl && avs_writedata[CTL_WAKE_BIT]) begin
                    st_d.state   = ST_OSC;
                    st_d.waking  = 1'b1;
                    st_d.osc_cnt = '0;
                end
            end
            default: st_d.state = ST_HOLD;
        endcase
        if (rst_src) begin
            st_d.state = ST_HOLD;
        end

        st_d.core_reset = (st_d.state == ST_HOLD) || (st_d.state == ST_TOUT)
                       || (st_d.state == ST_OSC && !st_d.waking);
        st_d.cpu_en     = sys_tick && (st_q.state == ST_RUN) && !rst_src && !st_q.noise;
        st_d.adc_en     = sys_tick && (st_q.state == ST_RUN);
        st_d.asy_en     = asy_edge;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q          <= '0;
            st_q.state    <= ST_HOLD;
            st_q.cfg_src  <= DEF_SRC;
            st_q.cfg_sut  <= DEF_SUT;
            st_q.cfg_div8 <= DEF_DIV8;
            st_q.src      <= DEF_SRC;
            st_q.sut      <= DEF_SUT;
            st_q.div8     <= DEF_DIV8;
            st_q.kind     <= KIND_RC8M;
            st_q.core_reset <= 1'b1;
            st_q.wdt_prev <= 1'b1;
            st_q.osc_prev <= 1'b1;
            st_q.asy_prev <= 1'b1;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_waitrequest      = avs_read && !st_q.rd_done;
    assign avs_readdata         = st_q.rdata;
    assign core_reset           = st_q.core_reset;
    assign core_clock_en        = st_q.cpu_en;
    assign converter_clock_en   = st_q.adc_en;
    assign async_timer_clock_en = st_q.asy_en;
    assign source_kind          = st_q.kind;
    assign crystal_range_select = st_q.src[3:1];
    assign clock_select_low_bit = st_q.src[0];
    assign fuse_fault           = st_q.fault;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_default_cfg;
        @(posedge clk) rst |=> (st_q.cfg_src == DEF_SRC && st_q.cfg_sut == DEF_SUT
                                && st_q.cfg_div8 == DEF_DIV8);
    endproperty
    a_default_cfg: assert property (p_default_cfg) else $error("bad default fuses");
    property p_hold_on_src;
        @(posedge clk) disable iff (rst)
        (rst_src && ce) |=> (core_reset && st_q.state == ST_HOLD);
    endproperty
    a_hold_on_src: assert property (p_hold_on_src) else $error("reset source ignored");
    property p_tout_wdt_only;
        @(posedge clk) disable iff (rst)
        (st_q.state == ST_TOUT && !wdt_edge && !rst_src && ce) |=> $stable(st_q.wdt_cnt);
    endproperty
    a_tout_wdt_only: assert property (p_tout_wdt_only) else $error("time-out miscounted");
    property p_tout_len;
        @(posedge clk) disable iff (rst)
        (st_q.state == ST_TOUT) |-> (st_q.wdt_cnt <= tout_len);
    endproperty
    a_tout_len: assert property (p_tout_len) else $error("time-out overrun");
    property p_release;
        @(posedge clk) disable iff (rst)
        $fell(core_reset) |-> ($past(st_q.state) == ST_OSC && st_q.state == ST_RUN);
    endproperty
    a_release: assert property (p_release) else $error("reset released early");
    property p_wake_path;
        @(posedge clk) disable iff (rst)
        (st_q.state == ST_SLEEP && wr_ctl && avs_writedata[CTL_WAKE_BIT] && !rst_src && ce)
            |=> (st_q.state == ST_OSC && !core_reset);
    endproperty
    a_wake_path: assert property (p_wake_path) else $error("wake took time-out");
    property p_async_sleep;
        @(posedge clk) disable iff (rst)
        (asy_edge && ce) |=> async_timer_clock_en;
    endproperty
    a_async_sleep: assert property (p_async_sleep) else $error("async clock lost");
    property p_noise;
        @(posedge clk) disable iff (rst)
        (sys_tick && st_q.state == ST_RUN && st_q.noise && ce)
            |=> (converter_clock_en && !core_clock_en);
    endproperty
    a_noise: assert property (p_noise) else $error("noise reduction gating wrong");
    property p_gate;
        @(posedge clk) disable iff (rst)
        core_clock_en |-> (!core_reset && $past(st_q.state) == ST_RUN);
    endproperty
    a_gate: assert property (p_gate) else $error("core clock before release");

endmodule : csss_sequencer

// ===== test/csss_osc_model.sv
// oscillator partner: watchdog, selected and timer oscillators
`timescale 1ns/1ps
module csss_osc_model #(
    parameter int HALF = 3
) (
    // clock and per-oscillator run requests
    input  wire logic        clk,
    input  wire logic [2:0]  run,
    // oscillator outputs: wdt, selected, async timer
    output logic      [2:0]  osc
);
    int cnt [3];
    // a stopped oscillator holds its level; half period stays >= 2 clk so each edge is seen
    initial begin
        osc = 3'h0;
        for (int i = 0; i < 3; i++) cnt[i] = 0;
    end
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (run[i]) begin
                if (cnt[i] == HALF - 1) begin
                    cnt[i] <= 0;
                    osc[i] <= ~osc[i];
                end else begin
                    cnt[i] <= cnt[i] + 1;
                end
            end
        end
    end
endmodule : csss_osc_model

// ===== test/testbench.sv
// self-checking bench of the start-up sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module testbench;
    import csss_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ext_reset_in = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
    logic avs_waitrequest, core_reset, core_clock_en, converter_clock_en;
    logic async_timer_clock_en, clock_select_low_bit, fuse_fault;
    logic [2:0] source_kind, crystal_range_select, osc, run = 3'h4;
    int bad_count = 0, samples_checked = 0, n_core, n_conv, n_asy;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (core_clock_en === 1'b1) n_core++;
        if (converter_clock_en === 1'b1) n_conv++;
        if (async_timer_clock_en === 1'b1) n_asy++;
    end
    csss_osc_model u_csss_osc_model (.clk(clk), .run(run), .osc(osc));
    csss_sequencer #(.TOUT_LONG_CYC(14'h0010), .CK_16K_CYC(17'h00020),
        .CK_32K_CYC(17'h00040)) u_csss_sequencer (
        .clk(clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
        .avs_byteenable(4'hF), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_reset_in(ext_reset_in),
        .wdt_osc_in(osc[0]), .sel_osc_in(osc[1]), .async_osc_in(osc[2]),
        .core_reset(core_reset), .core_clock_en(core_clock_en),
        .converter_clock_en(converter_clock_en),
        .async_timer_clock_en(async_timer_clock_en), .source_kind(source_kind),
        .crystal_range_select(crystal_range_select),
        .clock_select_low_bit(clock_select_low_bit), .fuse_fault(fuse_fault));
    // ----------------------------------------------------------------
    // closing, bus and oscillator tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic hang();
        bad_count++;
        $display("[ERR] %0t wait ran out", $time);
        report_and_stop();
    endtask : hang
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int k;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 50) hang();
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic state_is(input logic [2:0] s);
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(d[2:0], s)
    endtask : state_is
    // let exactly n rising edges of one oscillator happen, then stop it
    task automatic edges(input int w, input int n);
        int c, k;
        logic p;
        c = 0;
        p = osc[w];
        run[w] <= 1'b1;
        for (k = 0; k < n * 12 + 20 && c < n; k++) begin
            @(posedge clk);
            if (!p && osc[w]) c++;
            p = osc[w];
        end
        run[w] <= 1'b0;
        if (c < n) hang();
        repeat (8) @(posedge clk);
    endtask : edges
    task automatic osc_phase(input int n, input logic cr);
        edges(1, n - 1);
        state_is(3'h3);
        `CHK(core_reset, cr)
        edges(1, 1);
        state_is(3'h2);
        `CHK(core_reset, 1'b0)
    endtask : osc_phase
    function automatic logic [2:0] kind_of(input logic [3:0] s);
        if (s[3]) return 3'h4;
        case (s)
            4'h4, 4'h5: return 3'h3;
            4'h3: return 3'h1;
            4'h2: return 3'h2;
            4'h0: return 3'h0;
            default: return 3'h5;
        endcase
    endfunction : kind_of
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, REG_CONFIG, 32'h0);
        `CHK(d, 32'h00000022)
        bus(1'b0, 4'hC, 32'h0);
        `CHK(d, 32'h00000000)
        state_is(3'h0);
        `CHK(core_reset, 1'b1)
        // every select code while other reset sources hold the core
        for (int s = 0; s < 16; s++) begin
            bus(1'b1, REG_CONFIG, 32'h60 | s);
            repeat (3) @(posedge clk);
            `CHK(source_kind, kind_of(4'(s)))
            `CHK(crystal_range_select, 3'(s >> 1))
            `CHK(clock_select_low_bit, 1'(s))
            `CHK(fuse_fault, 1'(s == 1))
        end
        `CHK(n_asy > 0, 1'b1)
        // factory default: long time-out, then 6 + 19 cycles, divide by eight
        bus(1'b1, REG_CONFIG, 32'h22);
        ext_reset_in <= 1'b0;
        repeat (8) @(posedge clk);
        state_is(3'h1);
        edges(0, 15);
        state_is(3'h1);
        edges(0, 1);
        state_is(3'h3);
        osc_phase(25, 1'b1);
        n_core = 0;
        edges(1, 16);
        `CHK(n_core, 2)
        // sleep gates the core clock; wake costs only the start-up count
        bus(1'b1, REG_CONTROL, 32'h1);
        state_is(3'h6);
        n_core = 0;
        edges(1, 8);
        `CHK(n_core, 0)
        bus(1'b1, REG_CONTROL, 32'h2);
        osc_phase(6, 1'b0);
        bus(1'b1, REG_CONTROL, 32'h4);
        n_conv = 0;
        n_core = 0;
        edges(1, 16);
        `CHK(n_conv, 2)
        `CHK(n_core, 0)
        // noise level survives a reset source, so clear it before the next run
        bus(1'b1, REG_CONTROL, 32'h0);
        // crystal, low bit set, startup 01: no time-out, 16K + 19, no divide
        bus(1'b1, REG_CONFIG, 32'h59);
        ext_reset_in <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(source_kind, 3'h4)
        `CHK(crystal_range_select, 3'h4)
        ext_reset_in <= 1'b0;
        repeat (10) @(posedge clk);
        state_is(3'h3);
        osc_phase(51, 1'b1);
        n_core = 0;
        edges(1, 8);
        `CHK(n_core, 8)
        report_and_stop();
    end
endmodule : testbench
